/* rtl/pth_dev_end.sv */
/*
  Packet device end: task-file registers, phase posting with interrupt,
  PIO byte accounting, unit select, soft and command resets, and the
  interrupt line enable. Assumes the device core posts one phase at a time
  and presents read data ahead of each read strobe.
*/
`timescale 1ns/1ps
// Overview of operation
// - Sixteen-bit PIO length, low then high byte
// - Host loads length before packet command
// - Single-group commands: length is total size
// - Multi-burst commands: length is burst size
// - Device writes length, then raises interrupt
// - Length frozen while data request pending
// - Answer only when select bit matches number
// - Soft reset bit resets the device
// - Reset command also resets the device
// - Drive interrupt when enabled and selected
// - Otherwise interrupt line left undriven
module pth_dev_end #(
  parameter logic DEV_NUM = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        soft_reset_bit_in,
  pth_bus_if.dev           bus,
  input  wire logic        phase_req_in,
  input  wire logic [2:0]  phase_sel_in,
  input  wire logic [15:0] phase_len_in,
  input  wire logic        phase_release_in,
  output logic             phase_ready_out,
  output logic             phase_done_out,
  output logic             drq_out,
  output logic [15:0]      host_len_out,
  output logic [15:0]      wr_data_out,
  output logic             wr_strobe_out,
  input  wire logic [15:0] rd_data_in,
  output logic             rd_strobe_out,
  output logic             packet_cmd_out,
  output logic             soft_reset_out,
  output logic             cmd_reset_out,
  output logic             selected_out
);
  logic [15:0] transfer_length;
  logic [7:0]  phase_reason;
  logic [7:0]  unit_select;
  logic [7:0]  host_control;
  logic [15:0] bytes_left;
  logic        drq;
  logic        irq_pend;
  logic        post;
  logic        post_drq;
  logic        sel;
  logic        wr_sel;
  logic        rd_sel;
  logic        cmd_rst;
  logic        phase_clr;
  logic        data_acc;
  logic        last_acc;
  logic [2:0]  ph_code;

  // Phase code to {direction, request, command/data}
  function automatic logic [2:0] phase_bits(input logic [2:0] ph);
    case (ph)
      pth_pkg::PTH_PH_CMD_ACCEPT:     phase_bits = 3'b011;
      pth_pkg::PTH_PH_MESSAGE:        phase_bits = 3'b111;
      pth_pkg::PTH_PH_DATA_TO_HOST:   phase_bits = 3'b110;
      pth_pkg::PTH_PH_DATA_FROM_HOST: phase_bits = 3'b010;
      pth_pkg::PTH_PH_STATUS:         phase_bits = 3'b101;
      default:                        phase_bits = 3'b101;
    endcase
  endfunction

  // Selection and decoded strobes
  assign sel       = (unit_select[pth_pkg::UNIT_SEL_BIT] == DEV_NUM);
  assign wr_sel    = bus.wr && sel;
  assign rd_sel    = bus.rd && sel;
  assign cmd_rst   = wr_sel && (bus.addr == pth_pkg::OFS_COMMAND)
                     && (bus.wdata[7:0] == pth_pkg::CMD_RESET);
  assign phase_clr = host_control[pth_pkg::CTL_SOFT_RST_BIT] || cmd_rst;
  assign data_acc  = drq && (bus.addr == pth_pkg::OFS_DATA)
                     && ((wr_sel && !phase_reason[pth_pkg::REASON_IO_BIT])
                      || (rd_sel && phase_reason[pth_pkg::REASON_IO_BIT]));
  assign last_acc  = data_acc && (bytes_left <= pth_pkg::BYTES_PER_ACCESS);
  assign ph_code   = phase_bits(phase_sel_in); // {direction, request, command/data}

  assign phase_ready_out = !drq && !post && !phase_clr;
  assign drq_out         = drq;
  assign host_len_out    = transfer_length;
  assign soft_reset_out  = host_control[pth_pkg::CTL_SOFT_RST_BIT];
  assign selected_out    = sel;

  // Shared registers: both units latch select and control writes
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      unit_select  <= pth_pkg::UNIT_SEL_RST;
      host_control <= pth_pkg::HOST_CTL_RST;
    end else begin
      if (bus.wr && bus.addr == pth_pkg::OFS_UNIT_SEL) begin
        unit_select <= bus.wdata[7:0];
      end
      if (bus.wr && bus.addr == pth_pkg::OFS_HOST_CTL) begin
        host_control <= bus.wdata[7:0];
      end
    end
  end

  // Byte count: host writes it only while no data request stands
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in || phase_clr) begin
      transfer_length <= pth_pkg::LEN_RST;
    end else if (phase_req_in && phase_ready_out) begin
      transfer_length <= phase_len_in; // Set before the interrupt
    end else if (wr_sel && !drq && !post) begin // Frozen during request
      if (bus.addr == pth_pkg::OFS_LEN_LO) begin
        transfer_length[7:0] <= bus.wdata[7:0];
      end
      if (bus.addr == pth_pkg::OFS_LEN_HI) begin
        transfer_length[15:8] <= bus.wdata[7:0];
      end
    end
  end

  // Phase posting: reason and length land one cycle before interrupt
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in || phase_clr) begin
      phase_reason <= pth_pkg::REASON_RST;
      post         <= 1'b0;
      post_drq     <= 1'b0;
    end else begin
      post <= phase_req_in && phase_ready_out;
      if (phase_req_in && phase_ready_out) begin
        phase_reason <= pth_pkg::REASON_RST;
        phase_reason[pth_pkg::REASON_IO_BIT]      <= ph_code[2];
        phase_reason[pth_pkg::REASON_COD_BIT]     <= ph_code[0];
        phase_reason[pth_pkg::REASON_RELEASE_BIT] <= phase_release_in;
        post_drq <= ph_code[1];
      end
    end
  end

  // Data request and remaining bytes; the counter is kept apart so the
  // visible count never moves during the request
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in || phase_clr) begin
      drq            <= 1'b0;
      bytes_left     <= pth_pkg::LEN_RST;
      phase_done_out <= 1'b0;
    end else begin
      phase_done_out <= last_acc || (post && !post_drq);
      if (post) begin
        drq        <= post_drq && (transfer_length != pth_pkg::LEN_RST);
        bytes_left <= transfer_length;
      end else if (last_acc) begin
        drq        <= 1'b0;
        bytes_left <= pth_pkg::LEN_RST;
      end else if (data_acc) begin
        bytes_left <= bytes_left - pth_pkg::BYTES_PER_ACCESS;
      end
    end
  end

  // Interrupt pending: set by a post, cleared by reading the reason;
  // a post in the clearing cycle wins
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in || phase_clr) begin
      irq_pend <= 1'b0;
    end else if (post) begin
      irq_pend <= 1'b1; // Raised after the count is in place
    end else if (rd_sel && bus.addr == pth_pkg::OFS_REASON) begin
      irq_pend <= 1'b0;
    end
  end

  // Interrupt line driver
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      bus.intrq      <= 1'b0;
      bus.intrq_oe_n <= 1'b1;
    end else begin
      bus.intrq      <= irq_pend;
      bus.intrq_oe_n <= host_control[pth_pkg::CTL_INT_DIS_BIT] || !sel;
    end
  end

  // Read answers, registered one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      bus.rdata      <= 16'h0000;
      bus.rdata_oe_n <= 1'b1;
    end else begin
      bus.rdata_oe_n <= 1'b1;
      bus.rdata      <= 16'h0000;
      if (rd_sel) begin // Unselected unit never drives
        bus.rdata_oe_n <= 1'b0;
        case (bus.addr)
          pth_pkg::OFS_DATA:     bus.rdata <= data_acc ? rd_data_in : 16'h0000;
          pth_pkg::OFS_REASON:   bus.rdata <= {8'h00, phase_reason};
          pth_pkg::OFS_LEN_LO:   bus.rdata <= {8'h00, transfer_length[7:0]};
          pth_pkg::OFS_LEN_HI:   bus.rdata <= {8'h00, transfer_length[15:8]};
          pth_pkg::OFS_UNIT_SEL: bus.rdata <= {8'h00, unit_select};
          default:               bus.rdata_oe_n <= 1'b1;
        endcase
      end
    end
  end

  // Core-side strobes and write data
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      wr_data_out    <= 16'h0000;
      wr_strobe_out  <= 1'b0;
      rd_strobe_out  <= 1'b0;
      packet_cmd_out <= 1'b0;
      cmd_reset_out  <= 1'b0;
    end else begin
      wr_strobe_out  <= data_acc && bus.wr;
      rd_strobe_out  <= data_acc && bus.rd;
      packet_cmd_out <= wr_sel && (bus.addr == pth_pkg::OFS_COMMAND)
                        && (bus.wdata[7:0] == pth_pkg::CMD_PACKET);
      cmd_reset_out  <= cmd_rst;
      if (data_acc && bus.wr) begin
        wr_data_out <= bus.wdata;
      end
    end
  end
endmodule // pth_dev_end

/* rtl/pth_pkg.sv */
/*
  Shared constants for the packet task-file handshake: register offsets,
  field positions, phase codes, command codes and reset values.
  Assumes both ends and the bench import nothing and use pth_pkg::name.
*/
package pth_pkg;
  // Widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int REG_W  = 8;
  localparam int LEN_W  = 16;

  // Register offsets on the task-file address lines
  localparam logic [3:0] OFS_DATA     = 4'h0; // 16-bit PIO data window
  localparam logic [3:0] OFS_REASON   = 4'h2; // phase_reason, read only
  localparam logic [3:0] OFS_LEN_LO   = 4'h4; // transfer_length bits 7..0
  localparam logic [3:0] OFS_LEN_HI   = 4'h5; // transfer_length bits 15..8
  localparam logic [3:0] OFS_UNIT_SEL = 4'h6; // unit_select
  localparam logic [3:0] OFS_COMMAND  = 4'h7; // command, write only
  localparam logic [3:0] OFS_HOST_CTL = 4'he; // host_control, write only

  // Field positions
  localparam int REASON_COD_BIT     = 0; // command_or_data_flag
  localparam int REASON_IO_BIT      = 1; // transfer_direction_flag
  localparam int REASON_RELEASE_BIT = 2; // bus_released_flag
  localparam int UNIT_SEL_BIT       = 4; // device_select_bit
  localparam int CTL_INT_DIS_BIT    = 1; // interrupt_disable_bit
  localparam int CTL_SOFT_RST_BIT   = 2; // soft_reset_bit
  localparam int LEN_HI_LSB         = 8;

  // Reset values
  localparam logic [7:0]  REASON_RST   = 8'h00;
  localparam logic [7:0]  UNIT_SEL_RST = 8'h00;
  localparam logic [7:0]  HOST_CTL_RST = 8'h00;
  localparam logic [15:0] LEN_RST      = 16'h0000;

  // Bytes moved by one data-window access
  localparam logic [15:0] BYTES_PER_ACCESS = 16'h0002;

  // Command codes, arbitrary defaults
  localparam logic [7:0] CMD_PACKET = 8'ha0;
  localparam logic [7:0] CMD_RESET  = 8'h08;

  // Bus phases posted by the device core
  typedef enum logic [2:0] {
    PTH_PH_CMD_ACCEPT,
    PTH_PH_MESSAGE,
    PTH_PH_DATA_TO_HOST,
    PTH_PH_DATA_FROM_HOST,
    PTH_PH_STATUS
  } pth_phase_e;
endpackage : pth_pkg

/* rtl/pth_bus_if.sv */
/*
  Task-file bus between host adapter and packet device.
  Assumes one shared clock; tri-state drivers are resolved here to a
  pulled-down level, since the design files carry enables instead of Z.
*/
`timescale 1ns/1ps
interface pth_bus_if;
  logic [3:0]  addr;       // Register offset, host driven
  logic        wr;         // Write strobe, one cycle
  logic        rd;         // Read strobe, one cycle
  logic [15:0] wdata;      // Write data, host driven
  logic [15:0] rdata;      // Device read data
  logic        rdata_oe_n; // Low while the device drives rdata
  logic        intrq;      // Device interrupt value
  logic        intrq_oe_n; // Low while the device drives intrq
  logic [15:0] bus_rdata;  // Resolved data seen by the host
  logic        intrq_lvl;  // Resolved interrupt line seen by the host

  // Undriven lines read as low
  assign bus_rdata = rdata_oe_n ? 16'h0000 : rdata;
  assign intrq_lvl = intrq_oe_n ? 1'b0 : intrq;

  modport host (output addr, output wr, output rd, output wdata,
                input bus_rdata, input intrq_lvl);
  modport dev  (input addr, input wr, input rd, input wdata,
                output rdata, output rdata_oe_n, output intrq, output intrq_oe_n);
endinterface : pth_bus_if

/* rtl/pth_host_end.sv */
/*
  Host adapter end: turns user register requests into one-cycle bus
  strobes and returns read data. Assumes the device answers a read with
  data on the bus one cycle after the strobe, and that software orders
  its accesses (length before packet command).
*/
`timescale 1ns/1ps
module pth_host_end (
  input  wire logic        clk_in,
  input  wire logic        soft_reset_bit_in,
  pth_bus_if.host          bus,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [3:0]  req_addr_in,
  input  wire logic [15:0] req_wdata_in,
  output logic             req_ready_out,
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_data_out,
  output logic             intrq_out
);
  typedef enum logic [1:0] {PTH_H_IDLE, PTH_H_WAIT, PTH_H_TAKE} pth_host_state_e;
  pth_host_state_e state;
  logic [3:0]      addr;
  logic [15:0]     wdata;
  logic            wr;
  logic            rd;

  assign req_ready_out = (state == PTH_H_IDLE);
  assign bus.addr  = addr;
  assign bus.wdata = wdata;
  assign bus.wr    = wr;
  assign bus.rd    = rd;

  // Access sequencer; a read waits for the registered device answer
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      state <= PTH_H_IDLE;
      addr  <= 4'h0;
      wdata <= 16'h0000;
      wr    <= 1'b0;
      rd    <= 1'b0;
    end else begin
      wr <= 1'b0;
      rd <= 1'b0;
      case (state)
        PTH_H_IDLE: begin
          if (req_valid_in) begin
            addr  <= req_addr_in;  // Length writes precede the packet command
            wdata <= req_wdata_in; // Total or per-burst size is software's pick
            wr    <= req_write_in;
            rd    <= !req_write_in;
            state <= req_write_in ? PTH_H_IDLE : PTH_H_WAIT;
          end
        end
        PTH_H_WAIT: state <= PTH_H_TAKE;
        PTH_H_TAKE: state <= PTH_H_IDLE;
        default:    state <= PTH_H_IDLE;
      endcase
    end
  end

  // Read answer and interrupt line capture
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= 16'h0000;
      intrq_out     <= 1'b0;
    end else begin
      // The device registers its answer on the edge that leaves WAIT,
      // so the bus only holds it while this end sits in TAKE
      rsp_valid_out <= (state == PTH_H_TAKE);
      if (state == PTH_H_TAKE) begin
        rsp_data_out <= bus.bus_rdata;
      end
      intrq_out <= bus.intrq_lvl;
    end
  end
endmodule // pth_host_end

/* verification/pth_bus_assertions.sv */
/*
  Checker on the task-file bus signals of the packet handshake.
  Assumes one device of number DEV_NUM on the bus and a single clock.
*/
`timescale 1ns/1ps
module pth_bus_checker #(
  parameter logic DEV_NUM = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        soft_reset_bit_in,
  input  wire logic [3:0]  addr,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        rdata_oe_n,
  input  wire logic        intrq,
  input  wire logic        intrq_oe_n
);
  logic       unit_q; // Shadow select bit
  logic [1:0] ctl_q;  // Shadow soft reset and interrupt disable
  logic       sel_ok;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (soft_reset_bit_in);

  // Shadows follow host writes; every unit latches them, selected or not
  always_ff @(posedge clk_in) begin
    if (soft_reset_bit_in) begin
      unit_q <= 1'b0;
      ctl_q  <= 2'h0;
    end else if (wr && addr == pth_pkg::OFS_UNIT_SEL) begin
      unit_q <= wdata[pth_pkg::UNIT_SEL_BIT];
    end else if (wr && addr == pth_pkg::OFS_HOST_CTL) begin
      ctl_q <= {wdata[pth_pkg::CTL_SOFT_RST_BIT], wdata[pth_pkg::CTL_INT_DIS_BIT]};
    end
  end
  assign sel_ok = (unit_q == DEV_NUM);

  oe_cause_a: assert property (!rdata_oe_n |-> $past(rd))
    else $error("Data driven without a read");
  oe_pulse_a: assert property (!rdata_oe_n |=> rdata_oe_n)
    else $error("Data driven longer than one cycle");
  sel_read_a: assert property (rd && sel_ok && addr == pth_pkg::OFS_LEN_LO |=> !rdata_oe_n)
    else $error("Selected unit did not answer");
  unsel_read_a: assert property (rd && !sel_ok |=> rdata_oe_n)
    else $error("Unselected unit answered");
  wo_read_a: assert property (rd && addr == pth_pkg::OFS_HOST_CTL |=> rdata_oe_n)
    else $error("Write-only register answered");
  reason_rsv_a: assert property (!rdata_oe_n && $past(addr) == pth_pkg::OFS_REASON |-> rdata[15:3] == 13'h0000)
    else $error("Reserved reason bits set");
  irq_off_a: assert property (ctl_q[0] || !sel_ok |=> intrq_oe_n)
    else $error("Interrupt driven while disabled");
  irq_on_a: assert property (!ctl_q[0] && sel_ok ##1 intrq |-> !intrq_oe_n)
    else $error("Interrupt not driven while enabled");
  soft_reset_bit_irq_a: assert property (ctl_q[1] [*2] |=> !intrq)
    else $error("Interrupt survives soft reset");
  cmd_rst_a: assert property (wr && sel_ok && addr == pth_pkg::OFS_COMMAND && wdata[7:0] == pth_pkg::CMD_RESET |-> ##[2:3] !intrq)
    else $error("Interrupt survives reset command");

  // Main scenarios reached
  irq_seen_c: cover property (intrq && !intrq_oe_n);
  reason_rd_c: cover property (rd && addr == pth_pkg::OFS_REASON);
  data_rd_c: cover property (rd && addr == pth_pkg::OFS_DATA);
  soft_reset_bit_c: cover property (ctl_q[1]);
endmodule // pth_bus_checker

/* verification/packet_taskfile_handshake_tb.sv */
/*
  Bench: host end and device end meet in the bus interface; the bench plays
  host user and device core. Assumes a 25 MHz clock, one phase at a time.
*/
`timescale 1ns/1ps
module packet_taskfile_handshake_tb;
  logic        clk_in = 1'b0, soft_reset_bit_in = 1'b1, rq_v = 1'b0, rq_w = 1'b0;
  logic [3:0]  rq_a = 4'h0;
  logic [15:0] rq_d = 16'h0000, ph_len = 16'h0000, rsp_data, host_len;
  logic [15:0] rd_word = 16'hc35a; // Core data stays fixed: one tie only
  logic        ph_req = 1'b0, ph_rel = 1'b0, rq_rdy, rsp_v, irq_h, ph_rdy, drq, soft_reset_bit_o;
  logic [2:0]  ph_sel = 3'h0;
  logic        ph_done, wr_stb, rd_stb, pkt_cmd, cmd_rst_o, sel_o;
  logic [15:0] wr_dat;
  int          fail_count = 0, compares = 0, cycles = 0, rd_count = 0;

  always #20 clk_in = ~clk_in;

  pth_bus_if pth_bus_if_i ();
  pth_host_end pth_host_end_i (.clk_in(clk_in), .soft_reset_bit_in(soft_reset_bit_in), .bus(pth_bus_if_i),
    .req_valid_in(rq_v), .req_write_in(rq_w), .req_addr_in(rq_a), .req_wdata_in(rq_d),
    .req_ready_out(rq_rdy), .rsp_valid_out(rsp_v), .rsp_data_out(rsp_data), .intrq_out(irq_h));
  pth_dev_end #(.DEV_NUM(1'b0)) pth_dev_end_i (.clk_in(clk_in), .soft_reset_bit_in(soft_reset_bit_in),
    .bus(pth_bus_if_i), .phase_req_in(ph_req), .phase_sel_in(ph_sel), .phase_len_in(ph_len),
    .phase_release_in(ph_rel), .phase_ready_out(ph_rdy), .phase_done_out(ph_done),
    .drq_out(drq), .host_len_out(host_len), .wr_data_out(wr_dat), .wr_strobe_out(wr_stb),
    .rd_data_in(rd_word), .rd_strobe_out(rd_stb), .packet_cmd_out(pkt_cmd),
    .soft_reset_out(soft_reset_bit_o), .cmd_reset_out(cmd_rst_o), .selected_out(sel_o));
  pth_bus_checker #(.DEV_NUM(1'b0)) pth_bus_checker_i (.clk_in(clk_in), .soft_reset_bit_in(soft_reset_bit_in),
    .addr(pth_bus_if_i.addr), .wr(pth_bus_if_i.wr), .rd(pth_bus_if_i.rd),
    .wdata(pth_bus_if_i.wdata), .rdata(pth_bus_if_i.rdata),
    .rdata_oe_n(pth_bus_if_i.rdata_oe_n), .intrq(pth_bus_if_i.intrq),
    .intrq_oe_n(pth_bus_if_i.intrq_oe_n));

  task automatic end_of_test();
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      end_of_test();
    end
  end

  // Core read strobes, counted away from the edge that launches them
  always @(negedge clk_in) begin
    if (rd_stb === 1'b1) begin
      rd_count <= rd_count + 1;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] b(input logic v);
    return {15'h0000, v};
  endfunction
  // Host writes are taken at once; valid drops at the next falling edge
  task automatic hwr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk_in);
    {rq_v, rq_w, rq_a, rq_d} = {2'h3, a, d};
    @(negedge clk_in);
    rq_v = 1'b0;
  endtask
  // A read answers two edges after it is taken; bounded wait
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    int n = 0;
    @(negedge clk_in);
    {rq_v, rq_w, rq_a} = {2'h2, a};
    @(negedge clk_in);
    rq_v = 1'b0;
    while (rsp_v !== 1'b1 && n < 8) begin
      @(negedge clk_in);
      n++;
    end
    chk("answer", 16'h0001, b(rsp_v));
    chk(what, exp, rsp_data);
  endtask
  // Core posts a phase once ready, then lets the interrupt settle
  task automatic post(input pth_pkg::pth_phase_e s, input logic [15:0] len, input logic rel);
    int n = 0;
    @(negedge clk_in);
    while (ph_rdy !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    {ph_req, ph_sel, ph_len, ph_rel} = {1'b1, s, len, rel};
    @(negedge clk_in);
    ph_req = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic t_reset();
    rchk("len lo", pth_pkg::OFS_LEN_LO, 16'h0000);
    rchk("len hi", pth_pkg::OFS_LEN_HI, 16'h0000);
    rchk("reason", pth_pkg::OFS_REASON, 16'h0000);
    rchk("ctl", pth_pkg::OFS_HOST_CTL, 16'h0000);
    rchk("unmapped", 4'h8, 16'h0000);
  endtask
  task automatic t_len();
    hwr(pth_pkg::OFS_LEN_LO, 16'h0034);
    hwr(pth_pkg::OFS_LEN_HI, 16'h0012);
    @(negedge clk_in); // High byte lands on the edge after the take
    chk("len", 16'h1234, host_len);
    rchk("len hi", pth_pkg::OFS_LEN_HI, 16'h0012);
    hwr(pth_pkg::OFS_COMMAND, {8'h00, pth_pkg::CMD_PACKET});
    @(negedge clk_in);
    chk("packet cmd", 16'h0001, b(pkt_cmd));
  endtask
  // Every phase code, release flag on status, one word per phase with a data request
  task automatic t_phases();
    pth_pkg::pth_phase_e ps [5];
    logic [7:0]          er [5];
    ps = '{pth_pkg::PTH_PH_CMD_ACCEPT, pth_pkg::PTH_PH_MESSAGE, pth_pkg::PTH_PH_DATA_TO_HOST,
           pth_pkg::PTH_PH_DATA_FROM_HOST, pth_pkg::PTH_PH_STATUS};
    er = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h07};
    for (int i = 0; i < 5; i++) begin
      post(ps[i], 16'h0002, i == 4);
      chk("len", 16'h0002, host_len);
      chk("drq", b(i < 4), b(drq));
      chk("irq", 16'h0001, b(pth_bus_if_i.intrq_lvl));
      chk("host irq", 16'h0001, b(irq_h));
      rchk("reason", pth_pkg::OFS_REASON, {8'h00, er[i]});
      chk("irq clr", 16'h0000, b(pth_bus_if_i.intrq_lvl));
      if (i < 4 && er[i][1]) rchk("data", pth_pkg::OFS_DATA, rd_word);
      if (i < 4 && !er[i][1]) begin
        hwr(pth_pkg::OFS_DATA, 16'h1357);
        @(negedge clk_in);
        chk("wr strobe", 16'h0001, b(wr_stb));
        chk("wr data", 16'h1357, wr_dat);
        chk("done", 16'h0001, b(ph_done));
      end
      repeat (3) @(negedge clk_in);
      chk("drq end", 16'h0000, b(drq));
    end
  endtask
  // Length write during a pending request must be ignored
  task automatic t_hold();
    int n0;
    post(pth_pkg::PTH_PH_DATA_TO_HOST, 16'h0006, 1'b0);
    hwr(pth_pkg::OFS_LEN_LO, 16'h00ff);
    rchk("len held", pth_pkg::OFS_LEN_LO, 16'h0006);
    n0 = rd_count;
    for (int i = 0; i < 3; i++) begin
      chk("drq held", 16'h0001, b(drq));
      rchk("data", pth_pkg::OFS_DATA, rd_word);
    end
    repeat (2) @(negedge clk_in);
    chk("drq end", 16'h0000, b(drq));
    chk("rd strobes", 16'h0003, 16'(rd_count - n0));
    rchk("reason", pth_pkg::OFS_REASON, 16'h0002);
  endtask
  task automatic t_select();
    post(pth_pkg::PTH_PH_STATUS, 16'h0055, 1'b0);
    hwr(pth_pkg::OFS_UNIT_SEL, 16'h0010);
    repeat (3) @(negedge clk_in);
    chk("irq unsel", 16'h0000, b(pth_bus_if_i.intrq_lvl));
    chk("sel off", 16'h0000, b(sel_o));
    rchk("len unsel", pth_pkg::OFS_LEN_LO, 16'h0000);
    hwr(pth_pkg::OFS_UNIT_SEL, 16'h0000);
    repeat (3) @(negedge clk_in);
    chk("irq sel", 16'h0001, b(pth_bus_if_i.intrq_lvl));
    chk("sel on", 16'h0001, b(sel_o));
    rchk("len sel", pth_pkg::OFS_LEN_LO, 16'h0055);
    hwr(pth_pkg::OFS_HOST_CTL, 16'h0002);
    repeat (3) @(negedge clk_in);
    chk("irq dis", 16'h0000, b(pth_bus_if_i.intrq_lvl));
    hwr(pth_pkg::OFS_HOST_CTL, 16'h0000);
    rchk("reason", pth_pkg::OFS_REASON, 16'h0003);
  endtask
  task automatic t_resets();
    post(pth_pkg::PTH_PH_DATA_TO_HOST, 16'h0008, 1'b0);
    hwr(pth_pkg::OFS_HOST_CTL, 16'h0004);
    repeat (3) @(negedge clk_in);
    chk("soft_reset_bit", 16'h0001, b(soft_reset_bit_o));
    chk("drq soft_reset_bit", 16'h0000, b(drq));
    chk("len soft_reset_bit", 16'h0000, host_len);
    hwr(pth_pkg::OFS_HOST_CTL, 16'h0000);
    post(pth_pkg::PTH_PH_DATA_TO_HOST, 16'h0008, 1'b0);
    hwr(pth_pkg::OFS_COMMAND, {8'h00, pth_pkg::CMD_RESET});
    @(negedge clk_in);
    chk("cmd rst", 16'h0001, b(cmd_rst_o));
    repeat (2) @(negedge clk_in);
    chk("drq cmd", 16'h0000, b(drq));
    chk("len cmd", 16'h0000, host_len);
  endtask

  // Reset for twelve cycles, then the scenarios in turn
  initial begin
    repeat (12) @(negedge clk_in);
    soft_reset_bit_in = 1'b0;
    t_reset();
    t_len();
    t_phases();
    t_hold();
    t_select();
    t_resets();
    end_of_test();
  end
endmodule // packet_taskfile_handshake_tb
